// ---- include/bus_hs_pkg.sv ----
// shared constants and state codes for the system bus handshake block.
// assumes one 100 MHz clock and pins already synchronous to it.
package bus_hs_pkg;

    // clock period in ns
    localparam int CLK_PERIOD_NS   = 10;
    // default length of the low phase of the address strobe, in cycles
    localparam int STROBE_CYC_DEF  = 2;
    // default delay from register select to acknowledge, in cycles
    localparam int ACK_DELAY_DEF   = 1;
    // default number of interrupt sources
    localparam int INT_SRC_W_DEF   = 16;
    // counter width for the strobe and acknowledge timers
    localparam int CNT_W           = 4;
    // pin levels of the active-low strobes
    localparam logic PIN_ACTIVE    = 1'b0;
    localparam logic PIN_IDLE      = 1'b1;
    // direction strobe levels
    localparam logic DIR_READ      = 1'b1;
    localparam logic DIR_WRITE     = 1'b0;
    // protocol select value for the processor-style bus
    localparam logic PROTO_PROC    = 1'b1;

    typedef enum logic [2:0] {
        M_IDLE   = 3'b000,
        M_REQ    = 3'b001,
        M_OWN    = 3'b010,
        M_STROBE = 3'b011,
        M_END    = 3'b100
    } master_state_e;

endpackage : bus_hs_pkg

// ---- src/bus_master_slave_handshake.sv ----
// bus master arbitration and strobes, register slave acknowledge and
// interrupt pin of the host port. pins are split into out, enable and in;
// the surrounding pad or bench resolves the wire. inputs are synchronous.

// Behaviour
// - address strobe rises to end cycle
// - direction high for read, low write
// - interrupt asserted when enabled source pending
// - masked sources never activate interrupt
// - bus request driven low when requesting
// - bus request released when not requesting
// - grant acknowledge low only when ownership possible
// - grant acknowledge needs grant received
// - grant acknowledge needs address strobe inactive
// - grant acknowledge needs both size acks inactive
// - size acks signal register access complete
module bus_master_slave_handshake #(
    parameter int STROBE_CYC = bus_hs_pkg::STROBE_CYC_DEF,
    parameter int ACK_DELAY  = bus_hs_pkg::ACK_DELAY_DEF,
    parameter int INT_SRC_W  = bus_hs_pkg::INT_SRC_W_DEF
) (
    input  wire logic                 core_clk_i,
    input  wire logic                 reset_i,
    // user side of the master
    input  wire logic                 mem_req_i,
    input  wire logic                 mem_read_i,
    output logic                      mem_done_o,
    // user side of the slave and interrupt
    input  wire logic                 bus_protocol_select_i,
    output logic                      reg_access_o,
    output logic                      reg_write_o,
    input  wire logic [INT_SRC_W-1:0] int_status_i,
    input  wire logic [INT_SRC_W-1:0] int_mask_i,
    // bus pins
    output logic                      address_strobe_o,
    output logic                      address_strobe_oe_o,
    input  wire logic                 address_strobe_i,
    output logic                      memory_direction_strobe_o,
    output logic                      memory_direction_strobe_oe_o,
    output logic                      bus_request_out_o,
    output logic                      bus_request_out_oe_o,
    input  wire logic                 bus_grant_in_n_i,
    output logic                      grant_acknowledge_o,
    output logic                      grant_acknowledge_oe_o,
    input  wire logic                 reg_select_i,
    input  wire logic                 slave_direction_in_i,
    output logic                      reg_size_ack_low_o,
    output logic                      reg_size_ack_low_oe_o,
    input  wire logic                 reg_size_ack_low_i,
    output logic                      reg_size_ack_high_o,
    output logic                      reg_size_ack_high_oe_o,
    input  wire logic                 reg_size_ack_high_i,
    output logic                      interrupt_o,
    output logic                      interrupt_oe_o
);
    import bus_hs_pkg::*;

    localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);
    localparam logic [CNT_W-1:0] ACK_LAST    = CNT_W'(ACK_DELAY);

    master_state_e    state_r;
    master_state_e    state_nxt;
    logic [CNT_W-1:0] strobe_cnt_r;
    logic             read_r;
    logic [CNT_W-1:0] ack_cnt_r;
    logic             ack_on_r;
    logic             bus_free;
    logic             ack_start;

    assign bus_free = (bus_grant_in_n_i == PIN_ACTIVE) &&
                      (address_strobe_i == PIN_IDLE) &&
                      (reg_size_ack_low_i == PIN_IDLE) &&
                      (reg_size_ack_high_i == PIN_IDLE);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            M_IDLE: begin
                if (mem_req_i) begin
                    state_nxt = M_REQ;
                end
            end
            M_REQ: begin
                // take the bus only once free
                if (bus_free) begin
                    state_nxt = M_OWN;
                end
            end
            M_OWN: begin
                state_nxt = M_STROBE;
            end
            M_STROBE: begin
                if (strobe_cnt_r == STROBE_LAST) begin
                    state_nxt = M_END;
                end
            end
            M_END: begin
                state_nxt = M_IDLE;
            end
            default: begin
                state_nxt = M_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_r <= M_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            strobe_cnt_r <= '0;
        end else if (state_r == M_STROBE) begin
            strobe_cnt_r <= strobe_cnt_r + CNT_W'(1);
        end else begin
            strobe_cnt_r <= '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            read_r <= 1'b0;
        end else if (state_r == M_IDLE && mem_req_i) begin
            read_r <= mem_read_i;
        end
    end

    // pin drivers follow the next state so each pin is a flop
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            bus_request_out_o            <= PIN_ACTIVE;
            bus_request_out_oe_o         <= 1'b0;
            grant_acknowledge_o          <= PIN_ACTIVE;
            grant_acknowledge_oe_o       <= 1'b0;
            address_strobe_o             <= PIN_IDLE;
            address_strobe_oe_o          <= 1'b0;
            memory_direction_strobe_o    <= DIR_READ;
            memory_direction_strobe_oe_o <= 1'b0;
            mem_done_o                   <= 1'b0;
        end else begin
            // request pulled low only while asking
            bus_request_out_o         <= PIN_ACTIVE;
            bus_request_out_oe_o      <= (state_nxt == M_REQ);
            grant_acknowledge_o       <= PIN_ACTIVE;
            grant_acknowledge_oe_o    <= (state_nxt == M_OWN) || (state_nxt == M_STROBE) ||
                                         (state_nxt == M_END);
            // strobes driven only under grant acknowledge
            address_strobe_oe_o       <= (state_nxt == M_OWN) || (state_nxt == M_STROBE) ||
                                         (state_nxt == M_END);
            memory_direction_strobe_oe_o <= (state_nxt == M_OWN) || (state_nxt == M_STROBE) ||
                                            (state_nxt == M_END);
            // strobe low for the cycle, high to end it
            address_strobe_o          <= (state_nxt == M_STROBE) ? PIN_ACTIVE : PIN_IDLE;
            if (state_nxt == M_OWN) begin
                memory_direction_strobe_o <= read_r ? DIR_READ : DIR_WRITE;
            end
            mem_done_o                <= (state_nxt == M_END);
        end
    end

    // slave side: acks only in processor-style protocol
    assign ack_start = reg_select_i && (bus_protocol_select_i == PROTO_PROC) &&
                       !ack_on_r && (ack_cnt_r == ACK_LAST);

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ack_cnt_r <= '0;
        end else if (!reg_select_i || bus_protocol_select_i != PROTO_PROC) begin
            ack_cnt_r <= '0;
        end else if (ack_cnt_r != ACK_LAST) begin
            ack_cnt_r <= ack_cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ack_on_r     <= 1'b0;
            reg_access_o <= 1'b0;
            reg_write_o  <= 1'b0;
        end else begin
            // both acks low until the select drops
            if (ack_start) begin
                ack_on_r <= 1'b1;
            end else if (!reg_select_i) begin
                ack_on_r <= 1'b0;
            end
            reg_access_o <= ack_start;
            if (ack_start) begin
                reg_write_o <= (slave_direction_in_i == DIR_WRITE);
            end
        end
    end

    assign reg_size_ack_low_o     = PIN_ACTIVE;
    assign reg_size_ack_high_o    = PIN_ACTIVE;
    assign reg_size_ack_low_oe_o  = ack_on_r;
    assign reg_size_ack_high_oe_o = ack_on_r;

    // open collector interrupt, pulled low while enabled source pending
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            interrupt_oe_o <= 1'b0;
        end else begin
            interrupt_oe_o <= |(int_status_i & int_mask_i);
        end
    end
    assign interrupt_o = PIN_ACTIVE;

    property p_strobe_end;
        @(posedge core_clk_i) disable iff (reset_i)
        (state_r == M_STROBE && strobe_cnt_r == STROBE_LAST) |=>
            address_strobe_oe_o && address_strobe_o == PIN_IDLE ##1 !address_strobe_oe_o;
    endproperty
    a_strobe_end: assert property (p_strobe_end) else $error("strobe did not end cycle");

    property p_direction;
        @(posedge core_clk_i) disable iff (reset_i)
        memory_direction_strobe_oe_o |->
            memory_direction_strobe_o == (read_r ? DIR_READ : DIR_WRITE);
    endproperty
    a_direction: assert property (p_direction) else $error("direction strobe wrong");

    property p_int_on;
        @(posedge core_clk_i) disable iff (reset_i)
        (|(int_status_i & int_mask_i)) |=> interrupt_oe_o && interrupt_o == PIN_ACTIVE;
    endproperty
    a_int_on: assert property (p_int_on) else $error("interrupt not asserted");

    property p_int_masked;
        @(posedge core_clk_i) disable iff (reset_i)
        !(|(int_status_i & int_mask_i)) |=> !interrupt_oe_o;
    endproperty
    a_int_masked: assert property (p_int_masked) else $error("masked interrupt active");

    property p_request_low;
        @(posedge core_clk_i) disable iff (reset_i)
        (state_r == M_IDLE && mem_req_i) |=> bus_request_out_oe_o &&
            bus_request_out_o == PIN_ACTIVE;
    endproperty
    a_request_low: assert property (p_request_low) else $error("request not driven");

    property p_request_release;
        @(posedge core_clk_i) disable iff (reset_i)
        (state_r != M_REQ) |-> !bus_request_out_oe_o;
    endproperty
    a_request_release: assert property (p_request_release) else $error("request held");

    property p_gack_only_when_free;
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(grant_acknowledge_oe_o) |-> $past(bus_free) && $past(state_r) == M_REQ;
    endproperty
    a_gack_only_when_free: assert property (p_gack_only_when_free) else $error("early gack");

    property p_gack_needs_grant;
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(grant_acknowledge_oe_o) |-> $past(bus_grant_in_n_i) == PIN_ACTIVE;
    endproperty
    a_gack_needs_grant: assert property (p_gack_needs_grant) else $error("gack, no grant");

    property p_gack_needs_as_idle;
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(grant_acknowledge_oe_o) |-> $past(address_strobe_i) == PIN_IDLE;
    endproperty
    a_gack_needs_as_idle: assert property (p_gack_needs_as_idle) else $error("strobe busy");

    property p_gack_needs_acks_idle;
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(grant_acknowledge_oe_o) |->
            $past(reg_size_ack_low_i) == PIN_IDLE && $past(reg_size_ack_high_i) == PIN_IDLE;
    endproperty
    a_gack_needs_acks_idle: assert property (p_gack_needs_acks_idle) else $error("acks on");

    property p_ack_protocol;
        @(posedge core_clk_i) disable iff (reset_i)
        $rose(reg_size_ack_low_oe_o) |-> $past(reg_select_i) &&
            $past(bus_protocol_select_i) == PROTO_PROC ##1 reg_access_o == 1'b0;
    endproperty
    a_ack_protocol: assert property (p_ack_protocol) else $error("ack outside access");

    property p_strobe_under_gack;
        @(posedge core_clk_i) disable iff (reset_i)
        (address_strobe_oe_o || memory_direction_strobe_oe_o) |-> grant_acknowledge_oe_o;
    endproperty
    a_strobe_under_gack: assert property (p_strobe_under_gack) else $error("stray strobe");

endmodule : bus_master_slave_handshake

// ---- testbench/bus_arbiter_model.sv ----
// arbiter and bus-wire model facing the handshake block.
// assumes pull-ups on strobe and acks; the block's open-drain outs are low.
module bus_arbiter_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       request_oe_i,
    input  wire logic       grant_ack_oe_i,
    input  wire logic [3:0] grant_delay_i,
    input  wire logic       strobe_i,
    input  wire logic       strobe_oe_i,
    input  wire logic       ack_low_oe_i,
    input  wire logic       ack_high_oe_i,
    input  wire logic       hold_strobe_i,
    input  wire logic       hold_acks_i,
    output logic            grant_n_o,
    output logic            strobe_wire_o,
    output logic            ack_low_wire_o,
    output logic            ack_high_wire_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_r;
    always_ff @(posedge clk_i) begin
        if (rst_i || grant_ack_oe_i || !request_oe_i) begin
            grant_n_o <= 1'b1;
            wait_r    <= 4'h0;
        end else if (wait_r >= grant_delay_i) begin
            grant_n_o <= 1'b0;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
    // holds stand for a previous master or slave still on the bus
    assign strobe_wire_o   = strobe_oe_i ? strobe_i : !hold_strobe_i;
    assign ack_low_wire_o  = !(ack_low_oe_i || hold_acks_i);
    assign ack_high_wire_o = !(ack_high_oe_i || hold_acks_i);
endmodule : bus_arbiter_model

// ---- testbench/tb_bus_master_slave_handshake.sv ----
// self-checking bench of the bus handshake block with the arbiter model.
// inputs change on the falling edge; outputs are sampled there too.
module tb_bus_master_slave_handshake;
    timeunit 1ns;
    timeprecision 1ps;
    import bus_hs_pkg::*;
    localparam int SC = 2;
    logic clk = 0, rst = 1, mreq = 0, mrd = 0, proto = 1, sel = 0, sdir = 1;
    logic hold_s = 0, hold_a = 0, gnt_n, s_w, al_w, ah_w;
    logic [3:0] gdly = 4'h0;
    logic [15:0] ist = 16'h0000, imsk = 16'h0000;
    logic done, racc, rwr, as_o, as_oe, dir, dir_oe, rq, rq_oe, ga, ga_oe;
    logic al, al_oe, ah, ah_oe, irq, irq_oe;
    int fail_count = 0, checks = 0;
    bus_master_slave_handshake #(.STROBE_CYC(SC), .ACK_DELAY(1), .INT_SRC_W(16)) u_dut (
        .core_clk_i(clk), .reset_i(rst), .mem_req_i(mreq), .mem_read_i(mrd),
        .mem_done_o(done), .bus_protocol_select_i(proto), .reg_access_o(racc),
        .reg_write_o(rwr), .int_status_i(ist), .int_mask_i(imsk),
        .address_strobe_o(as_o), .address_strobe_oe_o(as_oe), .address_strobe_i(s_w),
        .memory_direction_strobe_o(dir), .memory_direction_strobe_oe_o(dir_oe),
        .bus_request_out_o(rq), .bus_request_out_oe_o(rq_oe), .bus_grant_in_n_i(gnt_n),
        .grant_acknowledge_o(ga), .grant_acknowledge_oe_o(ga_oe), .reg_select_i(sel),
        .slave_direction_in_i(sdir), .reg_size_ack_low_o(al), .reg_size_ack_low_oe_o(al_oe),
        .reg_size_ack_low_i(al_w), .reg_size_ack_high_o(ah),
        .reg_size_ack_high_oe_o(ah_oe), .reg_size_ack_high_i(ah_w),
        .interrupt_o(irq), .interrupt_oe_o(irq_oe));
    bus_arbiter_model u_arb (
        .clk_i(clk), .rst_i(rst), .request_oe_i(rq_oe), .grant_ack_oe_i(ga_oe),
        .grant_delay_i(gdly), .strobe_i(as_o), .strobe_oe_i(as_oe), .ack_low_oe_i(al_oe),
        .ack_high_oe_i(ah_oe), .hold_strobe_i(hold_s), .hold_acks_i(hold_a),
        .grant_n_o(gnt_n), .strobe_wire_o(s_w), .ack_low_wire_o(al_w),
        .ack_high_wire_o(ah_w));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic check(input string nm, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %b seen %b", nm, exp, got);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // one master cycle; holds stand until hold_n cycles of waiting have passed
    task automatic t_master(input logic rd, input logic [3:0] dly, input int hold_n);
        int n;
        logic gseen;
        gseen = 0;
        gdly = dly;
        mreq = 1;
        mrd = rd;
        @(negedge clk);
        mreq = 0;
        @(negedge clk);
        check("request oe", 1'b1, rq_oe);
        check("request out", 1'b0, rq);
        for (n = 0; n < 60 && ga_oe !== 1'b1; n++) begin
            check("strobe oe early", 1'b0, as_oe);
            check("dir oe early", 1'b0, dir_oe);
            if (n == hold_n) begin
                hold_s = 0;
                hold_a = 0;
            end
            gseen |= (gnt_n === 1'b0);
            @(negedge clk);
            if (ga_oe === 1'b1 && (hold_s || hold_a)) begin
                check("ack while bus busy", 1'b0, 1'b1);
            end
        end
        if (n == 60) begin
            check("grant ack timeout", 1'b1, 1'b0);
            print_verdict();
        end
        check("grant seen", 1'b1, gseen);
        check("grant ack out", 1'b0, ga);
        check("request released", 1'b0, rq_oe);
        check("strobe oe", 1'b1, as_oe);
        check("dir oe", 1'b1, dir_oe);
        check("direction", rd, dir);
        check("strobe idle first", 1'b1, as_o);
        repeat (SC) begin
            @(negedge clk);
            check("strobe low", 1'b0, as_o);
        end
        @(negedge clk);
        check("strobe end", 1'b1, as_o);
        check("mem done", 1'b1, done);
        @(negedge clk);
        check("strobe oe off", 1'b0, as_oe);
        check("ack oe off", 1'b0, ga_oe);
        check("done pulse", 1'b0, done);
        $display("test master rd=%b delay=%0d hold=%0d done", rd, dly, hold_n);
    endtask : t_master
    // one register access from the system side
    task automatic t_slave(input logic pr, input logic rd);
        proto = pr;
        sel = 1;
        sdir = rd;
        repeat (2) @(negedge clk);
        check("ack low oe", pr, al_oe);
        check("ack high oe", pr, ah_oe);
        check("reg access", pr, racc);
        if (pr) check("reg write", !rd, rwr);
        check("ack low out", 1'b0, al);
        check("ack high out", 1'b0, ah);
        @(negedge clk);
        check("access pulse", 1'b0, racc);
        check("ack held", pr, ah_oe);
        sel = 0;
        repeat (2) @(negedge clk);
        check("ack low off", 1'b0, al_oe);
        check("ack high off", 1'b0, ah_oe);
        $display("test slave proto=%b rd=%b done", pr, rd);
    endtask : t_slave
    task automatic t_interrupt(input logic [15:0] st, input logic [15:0] mk, input logic exp);
        ist = st;
        imsk = mk;
        repeat (2) @(negedge clk);
        check("interrupt oe", exp, irq_oe);
        check("interrupt out", 1'b0, irq);
        $display("test interrupt %h %h done", st, mk);
    endtask : t_interrupt
    initial begin
        repeat (3) @(negedge clk);
        rst = 0;
        check("strobe oe reset", 1'b0, as_oe);
        check("request oe reset", 1'b0, rq_oe);
        t_master(1'b1, 4'h0, 0);
        t_master(1'b0, 4'h5, 0);
        hold_s = 1;
        t_master(1'b1, 4'h0, 6);
        hold_a = 1;
        t_master(1'b0, 4'h1, 5);
        t_slave(1'b1, 1'b1);
        t_slave(1'b1, 1'b0);
        t_slave(1'b0, 1'b1);
        t_interrupt(16'h0001, 16'h0001, 1'b1);
        t_interrupt(16'h8000, 16'h7fff, 1'b0);
        t_interrupt(16'hffff, 16'h0000, 1'b0);
        t_interrupt(16'h0100, 16'h0300, 1'b1);
        t_interrupt(16'h0000, 16'hffff, 1'b0);
        print_verdict();
    end
endmodule : tb_bus_master_slave_handshake
